// file: rtl/cfg_regs_0a_11.sv
`timescale 1ns/10ps
`default_nettype none
module cfg_regs_0a_11 (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire cfg_slice_pkg::cfg_req_t req,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic hit,
  output logic [3:0] ecp_fifo_threshold,
  output logic [1:0] infrared_pin_routing,
  output logic [7:0] drive_rate_table_select,
  output cfg_slice_pkg::serial_ctrl_t serial_ctrl,
  output logic [7:0] test_control_a,
  output logic [7:0] test_control_b,
  output logic [7:0] test_control_c,
  input wire logic ir_tx_raw,
  input wire logic primary_ir_receive_pin,
  input wire logic secondary_ir_receive_pin,
  output logic ir_rx,
  output logic primary_ir_transmit_pin,
  output logic primary_ir_transmit_oe,
  output logic secondary_ir_transmit_pin,
  output logic secondary_ir_transmit_oe
);
  import cfg_slice_pkg::*;

  logic [7:0] thr_mux_r;
  logic [7:0] rate_r;
  logic [7:0] serial_r;
  logic [7:0] test_a_r;
  logic [7:0] test_b_r;
  logic [7:0] test_c_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  wire logic acc;
  wire logic wr_en;
  wire logic rd_en;
  wire logic [7:0] rd_mux;
  wire logic [7:0] thr_mux_nxt;

  // Index match helper
  function automatic logic sel(input logic [7:0] idx, input logic [7:0] want);
    sel = (idx == want);
  endfunction

  // Access decode, gated by configuration state
  assign acc = req.cfg_state && (req.index >= IDX_THR_MUX) && (req.index <= IDX_TEST_C); // R1
  assign wr_en = ce && acc && req.wr; // R1
  assign rd_en = ce && acc && req.rd; // R1
  assign hit = acc;
  assign thr_mux_nxt = req.wdata & THR_MUX_WMASK; // R3

  // Read selection; id and revision are constants
  assign rd_mux = sel(req.index, IDX_THR_MUX) ? thr_mux_r :
                  sel(req.index, IDX_RATE) ? rate_r :
                  sel(req.index, IDX_SERIAL) ? serial_r :
                  sel(req.index, IDX_DEV_ID) ? DEVICE_ID_VALUE : // R14
                  sel(req.index, IDX_REV) ? REVISION_VALUE : // R15
                  sel(req.index, IDX_TEST_A) ? test_a_r :
                  sel(req.index, IDX_TEST_B) ? test_b_r :
                  test_c_r;

  // Per register index matches
  wire logic sel_thr;
  wire logic sel_rate;
  wire logic sel_serial;
  wire logic sel_id;
  wire logic sel_rev;
  wire logic sel_ta;
  wire logic sel_tb;
  wire logic sel_tc;
  // Shared decode for the checks below
  assign sel_thr = sel(req.index, IDX_THR_MUX);
  assign sel_rate = sel(req.index, IDX_RATE);
  assign sel_serial = sel(req.index, IDX_SERIAL);
  assign sel_id = sel(req.index, IDX_DEV_ID);
  assign sel_rev = sel(req.index, IDX_REV);
  assign sel_ta = sel(req.index, IDX_TEST_A);
  assign sel_tb = sel(req.index, IDX_TEST_B);
  assign sel_tc = sel(req.index, IDX_TEST_C);

  // Writable registers; id and revision have no storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thr_mux_r <= RST_THR_MUX; // R2 R4
      rate_r <= RST_RATE; // R6
      serial_r <= RST_SERIAL; // R7
      test_a_r <= RST_TEST_A; // R16
      test_b_r <= RST_TEST_B; // R16
      test_c_r <= RST_TEST_C; // R17
    end else if (wr_en) begin
      if (sel(req.index, IDX_THR_MUX)) thr_mux_r <= thr_mux_nxt; // R2 R3 R4
      if (sel(req.index, IDX_RATE)) rate_r <= req.wdata; // R6
      if (sel(req.index, IDX_SERIAL)) serial_r <= req.wdata; // R8
      if (sel(req.index, IDX_TEST_A)) test_a_r <= req.wdata;
      if (sel(req.index, IDX_TEST_B)) test_b_r <= req.wdata;
      if (sel(req.index, IDX_TEST_C)) test_c_r <= req.wdata;
    end
  end

  // Registered read data, one cycle after request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else if (ce) begin
      rvalid_r <= rd_en; // R1
      if (rd_en) rdata_r <= rd_mux; // R19
    end
  end

  // Control outputs
  assign rdata = rdata_r;
  assign rdata_valid = rvalid_r;
  assign ecp_fifo_threshold = thr_mux_r[3:0]; // R2
  assign infrared_pin_routing = thr_mux_r[7:6]; // R4
  assign drive_rate_table_select = rate_r; // R6
  assign serial_ctrl = serial_r; // R10 R11 R12 R13
  assign test_control_a = test_a_r;
  assign test_control_b = test_b_r;
  assign test_control_c = test_c_r;

  ir_pin_router u_router (
    .route(thr_mux_r[7:6]),
    .rx_active_low(serial_r[0]),
    .tx_active_low(serial_r[1]),
    .ir_tx_raw(ir_tx_raw),
    .primary_ir_receive_pin(primary_ir_receive_pin),
    .secondary_ir_receive_pin(secondary_ir_receive_pin),
    .ir_rx(ir_rx),
    .primary_ir_transmit_pin(primary_ir_transmit_pin),
    .primary_ir_transmit_oe(primary_ir_transmit_oe),
    .secondary_ir_transmit_pin(secondary_ir_transmit_pin),
    .secondary_ir_transmit_oe(secondary_ir_transmit_oe)
  );

  // Checks
  chk_no_cfg_write: assert property (@(posedge clk) disable iff (!nrst) // R1
    (!req.cfg_state && req.wr) |=> $stable(thr_mux_r) && $stable(serial_r))
    else $error("register changed outside configuration state");
  chk_rsvd_bits_zero: assert property (@(posedge clk) disable iff (!nrst) // R3
    thr_mux_r[5:4] == 2'b00) else $error("reserved bits of 0A nonzero");
  chk_thr_write: assert property (@(posedge clk) disable iff (!nrst) // R2
    (wr_en && req.index == IDX_THR_MUX) |=> ecp_fifo_threshold == $past(req.wdata[3:0]))
    else $error("threshold not written");
  chk_route_off: assert property (@(posedge clk) disable iff (!nrst) // R5
    infrared_pin_routing == 2'b11 |-> !primary_ir_transmit_oe && !secondary_ir_transmit_oe)
    else $error("transmitters driven while routed off");
  chk_route_one: assert property (@(posedge clk) disable iff (!nrst) // R5
    !(primary_ir_transmit_oe && secondary_ir_transmit_oe)) else $error("both transmitters on");
  chk_rate_write: assert property (@(posedge clk) disable iff (!nrst) // R6
    (wr_en && req.index == IDX_RATE) |=> rate_r == $past(req.wdata))
    else $error("rate select not written");
  chk_id_read: assert property (@(posedge clk) disable iff (!nrst) // R14
    (rd_en && req.index == IDX_DEV_ID) |=> rdata == DEVICE_ID_VALUE && rdata_valid)
    else $error("id read wrong");
  chk_rev_read: assert property (@(posedge clk) disable iff (!nrst) // R15
    (rd_en && req.index == IDX_REV) |=> rdata == REVISION_VALUE)
    else $error("revision read wrong");
  chk_tx_polarity: assert property (@(posedge clk) disable iff (!nrst) // R9
    primary_ir_transmit_pin == (ir_tx_raw ^ serial_ctrl.tx_active_low))
    else $error("transmit polarity wrong");
  chk_rx_polarity: assert property (@(posedge clk) disable iff (!nrst) // R8
    (infrared_pin_routing == 2'b00) |-> ir_rx == (primary_ir_receive_pin ^ serial_r[0]))
    else $error("receive polarity wrong");

  // State holds unless its own write is taken
  chk_thr_hold: assert property (@(posedge clk) disable iff (!nrst) // R1
    !(wr_en && sel_thr)
    |=> $stable(thr_mux_r))
    else $error("index 0A changed without write");
  chk_rate_hold: assert property (@(posedge clk) disable iff (!nrst) // R1
    !(wr_en && sel_rate)
    |=> $stable(rate_r))
    else $error("index 0B changed without write");
  chk_serial_hold: assert property (@(posedge clk) disable iff (!nrst) // R1
    !(wr_en && sel_serial)
    |=> $stable(serial_r))
    else $error("index 0C changed without write");
  chk_test_a_hold: assert property (@(posedge clk) disable iff (!nrst) // R16
    !(wr_en && sel_ta)
    |=> $stable(test_a_r))
    else $error("index 0F changed without write");
  chk_test_b_hold: assert property (@(posedge clk) disable iff (!nrst) // R16
    !(wr_en && sel_tb)
    |=> $stable(test_b_r))
    else $error("index 10 changed without write");
  chk_test_c_hold: assert property (@(posedge clk) disable iff (!nrst) // R17
    !(wr_en && sel_tc)
    |=> $stable(test_c_r))
    else $error("index 11 changed without write");
  chk_ce_freeze: assert property (@(posedge clk) disable iff (!nrst) // R1
    !ce
    |=> $stable(rdata) && $stable(rdata_valid))
    else $error("read side moved with enable low");
  chk_ce_regs: assert property (@(posedge clk) disable iff (!nrst) // R1
    !ce
    |=> $stable(thr_mux_r) && $stable(rate_r) && $stable(serial_r))
    else $error("register moved with enable low");
  chk_rdata_hold: assert property (@(posedge clk) disable iff (!nrst) // R1
    !rd_en
    |=> $stable(rdata))
    else $error("read data changed without read");

  // Access decode
  chk_state_gate: assert property (@(posedge clk) disable iff (!nrst) // R1
    !req.cfg_state
    |-> !hit)
    else $error("hit outside configuration state");
  chk_range_low: assert property (@(posedge clk) disable iff (!nrst) // R1
    (req.index < IDX_THR_MUX)
    |-> !hit)
    else $error("hit below slice");
  chk_range_high: assert property (@(posedge clk) disable iff (!nrst) // R1
    (req.index > IDX_TEST_C)
    |-> !hit)
    else $error("hit above slice");
  chk_hit_inside: assert property (@(posedge clk) disable iff (!nrst) // R1
    (req.cfg_state && sel_serial)
    |-> hit)
    else $error("no hit inside slice");
  chk_read_pulse: assert property (@(posedge clk) disable iff (!nrst) // R1
    rd_en
    |=> rdata_valid)
    else $error("taken read gave no valid");
  chk_read_only_taken: assert property (@(posedge clk) disable iff (!nrst) // R1
    (ce && !rd_en)
    |=> !rdata_valid)
    else $error("valid without taken read");
  chk_refused_read: assert property (@(posedge clk) disable iff (!nrst) // R1
    (ce && req.rd && !req.cfg_state)
    |=> !rdata_valid)
    else $error("read answered outside configuration state");

  // Writes land in the next cycle
  chk_serial_write: assert property (@(posedge clk) disable iff (!nrst) // R8
    (wr_en && sel_serial)
    |=> serial_r == $past(req.wdata))
    else $error("serial mode not written");
  chk_route_write: assert property (@(posedge clk) disable iff (!nrst) // R4
    (wr_en && sel_thr)
    |=> infrared_pin_routing == $past(req.wdata[7:6]))
    else $error("routing not written");
  chk_rsvd_write: assert property (@(posedge clk) disable iff (!nrst) // R3
    (wr_en && sel_thr)
    |=> thr_mux_r[5:4] == 2'b00)
    else $error("reserved bits took a write");
  chk_test_a_write: assert property (@(posedge clk) disable iff (!nrst) // R16
    (wr_en && sel_ta)
    |=> test_control_a == $past(req.wdata))
    else $error("index 0F not written");
  chk_test_b_write: assert property (@(posedge clk) disable iff (!nrst) // R16
    (wr_en && sel_tb)
    |=> test_control_b == $past(req.wdata))
    else $error("index 10 not written");
  chk_test_c_write: assert property (@(posedge clk) disable iff (!nrst) // R17
    (wr_en && sel_tc)
    |=> test_control_c == $past(req.wdata))
    else $error("index 11 not written");
  chk_id_no_store: assert property (@(posedge clk) disable iff (!nrst) // R19
    (wr_en && (sel_id || sel_rev))
    |=> $stable(thr_mux_r) && $stable(rate_r) && $stable(serial_r))
    else $error("read-only write touched storage");

  // Read data is the value held at the taken edge
  chk_thr_read: assert property (@(posedge clk) disable iff (!nrst) // R3
    (rd_en && sel_thr)
    |=> rdata == $past(thr_mux_r))
    else $error("index 0A read wrong");
  chk_rate_read: assert property (@(posedge clk) disable iff (!nrst) // R6
    (rd_en && sel_rate)
    |=> rdata == $past(rate_r))
    else $error("index 0B read wrong");
  chk_serial_read: assert property (@(posedge clk) disable iff (!nrst) // R7
    (rd_en && sel_serial)
    |=> rdata == $past(serial_r))
    else $error("index 0C read wrong");
  chk_test_a_read: assert property (@(posedge clk) disable iff (!nrst) // R16
    (rd_en && sel_ta)
    |=> rdata == $past(test_a_r))
    else $error("index 0F read wrong");
  chk_test_b_read: assert property (@(posedge clk) disable iff (!nrst) // R16
    (rd_en && sel_tb)
    |=> rdata == $past(test_b_r))
    else $error("index 10 read wrong");
  chk_test_c_read: assert property (@(posedge clk) disable iff (!nrst) // R17
    (rd_en && sel_tc)
    |=> rdata == $past(test_c_r))
    else $error("index 11 read wrong");
  chk_rev_valid: assert property (@(posedge clk) disable iff (!nrst) // R15
    (rd_en && sel_rev)
    |=> rdata_valid)
    else $error("revision read gave no valid");

  // Serial control fields
  chk_duplex_map: assert property (@(posedge clk) disable iff (!nrst) // R10
    serial_ctrl.half_duplex == serial_r[2])
    else $error("duplex field misplaced");
  chk_mode_map: assert property (@(posedge clk) disable iff (!nrst) // R11
    serial_ctrl.mode == serial_r[5:3])
    else $error("mode field misplaced");
  chk_speed1_map: assert property (@(posedge clk) disable iff (!nrst) // R12
    serial_ctrl.uart1_hs == serial_r[6])
    else $error("first speed bit misplaced");
  chk_speed2_map: assert property (@(posedge clk) disable iff (!nrst) // R13
    serial_ctrl.uart2_hs == serial_r[7])
    else $error("second speed bit misplaced");

  // Pin routing
  chk_primary_oe: assert property (@(posedge clk) disable iff (!nrst) // R5
    (infrared_pin_routing == ROUTE_PRIMARY)
    |-> primary_ir_transmit_oe && !secondary_ir_transmit_oe)
    else $error("primary route drives wrong pin");
  chk_secondary_oe: assert property (@(posedge clk) disable iff (!nrst) // R5
    (infrared_pin_routing == ROUTE_SECONDARY)
    |-> secondary_ir_transmit_oe && !primary_ir_transmit_oe)
    else $error("secondary route drives wrong pin");
  chk_reserved_route: assert property (@(posedge clk) disable iff (!nrst) // R5
    (infrared_pin_routing == ROUTE_RESERVED)
    |-> !primary_ir_transmit_oe && !secondary_ir_transmit_oe)
    else $error("reserved route drives a pin");
  chk_rx_secondary: assert property (@(posedge clk) disable iff (!nrst) // R8
    (infrared_pin_routing == ROUTE_SECONDARY)
    |-> ir_rx == (secondary_ir_receive_pin ^ serial_r[0]))
    else $error("secondary receive wrong");
  chk_tx_secondary: assert property (@(posedge clk) disable iff (!nrst) // R9
    secondary_ir_transmit_pin == (ir_tx_raw ^ serial_r[1]))
    else $error("secondary transmit polarity wrong");

  cov_route_off: cover property (@(posedge clk) disable iff (!nrst)
    infrared_pin_routing == ROUTE_OFF);
  cov_frozen_write: cover property (@(posedge clk) disable iff (!nrst)
    !ce && acc && req.wr);
  cov_serial_write: cover property (@(posedge clk) disable iff (!nrst)
    wr_en && req.index == IDX_SERIAL);
  cov_route_secondary: cover property (@(posedge clk) disable iff (!nrst)
    infrared_pin_routing == 2'b01);
  cov_id_read: cover property (@(posedge clk) disable iff (!nrst)
    rd_en && req.index == IDX_DEV_ID);
endmodule
`default_nettype wire

// file: rtl/cfg_slice_pkg.sv
// What this block does
// R1 - Registers respond only in configuration state with matching index selected.
// R2 - Index 0A resets to zero; low nibble sets parallel port FIFO threshold.
// R3 - Index 0A bits five and four ignore writes and read zero.
// R4 - Index 0A bits seven and six select infrared routing, reset to default.
// R5 - Routing 00 primary pins, 01 secondary, 10 reserved, 11 transmitters high-Z.
// R6 - Index 0B resets zero; two-bit rate table select per drive, drive 0 low.
// R7 - Index 0C resets to 02 hexadecimal.
// R8 - Index 0C bit 0 sets second serial receive polarity, 1 active low.
// R9 - Index 0C bit 1 sets second serial transmit polarity, default active low.
// R10 - Index 0C bit 2 selects duplex: 0 full, 1 half.
// R11 - Index 0C bits 5:3 select second serial mode; others reserved.
// R12 - Index 0C bit 6 enables first serial high-speed mode.
// R13 - Index 0C bit 7 enables second serial high-speed mode.
// R14 - Index 0D is read-only and returns a fixed identification code.
// R15 - Index 0E is read-only and returns the silicon revision level.
// R16 - Test registers at 0F and 10 reset to zero, all bits reserved.
// R17 - Test register at 11 resets to 80 hexadecimal, all bits reserved.
// R18 - Host software must not set any test mode bit.
// R19 - Writes to identification and revision registers have no effect.
package cfg_slice_pkg;
  localparam logic [7:0] IDX_THR_MUX = 8'h0A;
  localparam logic [7:0] IDX_RATE = 8'h0B;
  localparam logic [7:0] IDX_SERIAL = 8'h0C;
  localparam logic [7:0] IDX_DEV_ID = 8'h0D;
  localparam logic [7:0] IDX_REV = 8'h0E;
  localparam logic [7:0] IDX_TEST_A = 8'h0F;
  localparam logic [7:0] IDX_TEST_B = 8'h10;
  localparam logic [7:0] IDX_TEST_C = 8'h11;
  localparam logic [7:0] RST_THR_MUX = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_SERIAL = 8'h02;
  localparam logic [7:0] RST_TEST_A = 8'h00;
  localparam logic [7:0] RST_TEST_B = 8'h00;
  localparam logic [7:0] RST_TEST_C = 8'h80;
  // Writable bits of index 0A; bits 5:4 are reserved
  localparam logic [7:0] THR_MUX_WMASK = 8'hCF;
  // Arbitrary neutral identification and revision values
  localparam logic [7:0] DEVICE_ID_VALUE = 8'h5A;
  localparam logic [7:0] REVISION_VALUE = 8'h00;
  localparam int N_DRIVES = 4;

  typedef enum logic [1:0] {
    ROUTE_PRIMARY = 2'b00,
    ROUTE_SECONDARY = 2'b01,
    ROUTE_RESERVED = 2'b10,
    ROUTE_OFF = 2'b11
  } ir_route_t;

  typedef enum logic [2:0] {
    SMODE_STANDARD = 3'b000,
    SMODE_HP_SERIAL_INFRARED_MODE = 3'b001,
    SMODE_ASKIR = 3'b010
  } serial_mode_t;

  // Host side access carrier
  typedef struct packed {
    logic cfg_state;
    logic [7:0] index;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cfg_req_t;

  // Decoded serial mode fields
  typedef struct packed {
    logic uart2_hs;
    logic uart1_hs;
    logic [2:0] mode;
    logic half_duplex;
    logic tx_active_low;
    logic rx_active_low;
  } serial_ctrl_t;
endpackage

// file: rtl/ir_pin_router.sv
`timescale 1ns/10ps
`default_nettype none
// Routes the second serial infrared signals onto one of two pin pairs
module ir_pin_router (
  input wire logic [1:0] route,
  input wire logic rx_active_low,
  input wire logic tx_active_low,
  input wire logic ir_tx_raw,
  input wire logic primary_ir_receive_pin,
  input wire logic secondary_ir_receive_pin,
  output logic ir_rx,
  output logic primary_ir_transmit_pin,
  output logic primary_ir_transmit_oe,
  output logic secondary_ir_transmit_pin,
  output logic secondary_ir_transmit_oe
);
  import cfg_slice_pkg::*;
  wire logic use_sec;
  wire logic tx_drv;
  wire logic rx_pin;
  // Pin selection and polarity
  assign use_sec = (route == ROUTE_SECONDARY); // R5
  assign tx_drv = ir_tx_raw ^ tx_active_low; // R9
  assign rx_pin = use_sec ? secondary_ir_receive_pin : primary_ir_receive_pin; // R5
  assign ir_rx = rx_pin ^ rx_active_low; // R8
  assign primary_ir_transmit_pin = tx_drv;
  assign secondary_ir_transmit_pin = tx_drv;
  assign primary_ir_transmit_oe = (route == ROUTE_PRIMARY); // R5
  assign secondary_ir_transmit_oe = use_sec; // R5
endmodule
`default_nettype wire

// file: dv/superio_config_regs_0a_11_bench.sv
`timescale 1ns/10ps
`default_nettype none
// Compare, count and report one value
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module superio_config_regs_0a_11_bench;
  import cfg_slice_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic ir_tx_raw = 1'b0;
  logic prx = 1'b1;
  logic srx = 1'b0;
  cfg_req_t req = '0;
  logic [7:0] rdata, dr, ta, tb, tc;
  logic rdata_valid, hit, ptx, poe, stx, soe, ir_rx;
  logic [3:0] thr;
  logic [1:0] route;
  serial_ctrl_t sc;
  int bad_count = 0;
  int num_checks = 0;
  // 8 ns clock
  always #4 clk = ~clk;
  cfg_regs_0a_11 i_cfg_regs_0a_11 (.clk(clk), .nrst(nrst), .ce(ce), .req(req),
    .rdata(rdata), .rdata_valid(rdata_valid), .hit(hit), .ecp_fifo_threshold(thr),
    .infrared_pin_routing(route), .drive_rate_table_select(dr), .serial_ctrl(sc),
    .test_control_a(ta), .test_control_b(tb), .test_control_c(tc),
    .ir_tx_raw(ir_tx_raw), .primary_ir_receive_pin(prx),
    .secondary_ir_receive_pin(srx), .ir_rx(ir_rx), .primary_ir_transmit_pin(ptx),
    .primary_ir_transmit_oe(poe), .secondary_ir_transmit_pin(stx),
    .secondary_ir_transmit_oe(soe));
  // One access held for one taken edge, then idle
  task automatic acc(input logic cs, input logic [7:0] idx, input logic w,
      input logic r, input logic [7:0] d);
    @(posedge clk);
    req <= '{cfg_state: cs, index: idx, wr: w, rd: r, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    acc(1'b1, idx, 1'b0, 1'b1, 8'h00);
    `CHK(rdata_valid, 1'b1)
    `CHK(rdata, e)
    @(posedge clk);
    #1;
    `CHK(rdata_valid, 1'b0)
  endtask
  // Reset values; test registers are never written
  task automatic t_reset;
    logic [7:0] exp_v [8] = '{8'h00, 8'h00, 8'h02, DEVICE_ID_VALUE, REVISION_VALUE,
      8'h00, 8'h00, 8'h80};
    for (int i = 0; i < 8; i++) begin
      rd(8'h0A + 8'(i), exp_v[i]);
    end
    `CHK(ta, 8'h00)
    `CHK(tb, 8'h00)
    `CHK(tc, 8'h80)
  endtask
  // Field writes, reserved bits and read-only places
  task automatic t_fields;
    acc(1'b1, IDX_THR_MUX, 1'b1, 1'b0, 8'hFF);
    rd(IDX_THR_MUX, 8'hCF);
    `CHK(thr, 4'hF)
    `CHK(route, 2'b11)
    acc(1'b1, IDX_RATE, 1'b1, 1'b0, 8'hC6);
    `CHK(dr, 8'hC6)
    acc(1'b1, IDX_SERIAL, 1'b1, 1'b0, 8'hD4);
    `CHK(sc.uart2_hs, 1'b1)
    `CHK(sc.uart1_hs, 1'b1)
    `CHK(sc.mode, SMODE_ASKIR)
    `CHK(sc.half_duplex, 1'b1)
    acc(1'b1, IDX_SERIAL, 1'b1, 1'b0, 8'h08);
    `CHK(sc, 8'h08)
    acc(1'b1, IDX_DEV_ID, 1'b1, 1'b0, 8'hFF);
    acc(1'b1, IDX_REV, 1'b1, 1'b0, 8'hFF);
    rd(IDX_DEV_ID, DEVICE_ID_VALUE);
    rd(IDX_REV, REVISION_VALUE);
  endtask
  // Accesses outside configuration state, index or clock enable
  task automatic t_refused;
    @(posedge clk);
    req <= '{cfg_state: 1'b1, index: IDX_TEST_C, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
    #1;
    `CHK(hit, 1'b1)
    @(posedge clk);
    req <= '{cfg_state: 1'b1, index: 8'h09, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
    #1;
    `CHK(hit, 1'b0)
    acc(1'b0, IDX_RATE, 1'b1, 1'b1, 8'h11);
    `CHK(rdata_valid, 1'b0)
    acc(1'b1, 8'h12, 1'b1, 1'b1, 8'h11);
    `CHK(rdata_valid, 1'b0)
    ce <= 1'b0;
    acc(1'b1, IDX_RATE, 1'b1, 1'b1, 8'h11);
    `CHK(rdata_valid, 1'b0)
    ce <= 1'b1;
    rd(IDX_RATE, 8'hC6);
  endtask
  // Every routing code with both polarities
  task automatic t_route;
    for (int r = 0; r < 4; r++) begin
      for (int p = 0; p < 2; p++) begin
        acc(1'b1, IDX_SERIAL, 1'b1, 1'b0, {6'h00, 1'(p), 1'(p)});
        acc(1'b1, IDX_THR_MUX, 1'b1, 1'b0, {2'(r), 6'h05});
        ir_tx_raw <= 1'(r);
        @(posedge clk);
        #1;
        `CHK(poe, 1'(r == 0))
        `CHK(soe, 1'(r == 1))
        `CHK(ptx, 1'(r) ^ 1'(p))
        `CHK(stx, 1'(r) ^ 1'(p))
        `CHK(ir_rx, 1'(r != 1) ^ 1'(p))
      end
    end
  endtask
  // Reset in mid run restores defaults
  task automatic t_rereset;
    @(posedge clk);
    nrst <= 1'b0;
    #1;
    `CHK(route, 2'b00)
    `CHK(sc, 8'h02)
    `CHK(dr, 8'h00)
    @(posedge clk);
    nrst <= 1'b1;
    rd(IDX_THR_MUX, 8'h00);
  endtask
  // Counts and verdict
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_fields();
    t_refused();
    t_route();
    t_rereset();
    test_done();
  end
  // Watchdog
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
